// ---- dv/iopif_ctrl_model.sv ----
// Controller model that delivers cyclic output data and parameters over APB
`timescale 1ns/1ns
`default_nettype none
module iopif_ctrl_model (
	// APB master side
	input wire logic pclk,
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [7:0] paddr,
	output logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr
);
	// Bus idle from time zero
	initial
	begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h00000000;
	end

	// One transfer; request held until pready is sampled high, startup parameters go here
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic e);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// Stale data must not look valid once released
		pwdata <= ~d;
	endtask : xfer
endmodule : iopif_ctrl_model
`default_nettype wire

// ---- dv/tb.sv ----
// Self-checking bench for the process image and failsafe block
`timescale 1ns/1ns
`default_nettype none
module tb;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [7:0] paddr, in_image, alarm_entry, flt;
	logic [31:0] pwdata, prdata, status_word;
	logic [3:0] in_pin4, in_pin2, out_short, out_overload, dout;
	logic act_short, act_under, act_surge, sen_overload, sen_under, sen_surge, overtemp;
	logic station_fault_lamp, alarm_incoming, alarm_outgoing, irq;
	int n_errors = 0;
	int num_checks = 0;
	// Expected status and diagnostic bits per fault slot of flt
	localparam logic [7:0] ST_EXP [8] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 8'h20, 8'h00, 8'h00};
	localparam logic [7:0] DG_EXP [8] = '{8'h40, 8'h80, 8'h20, 8'h10, 8'h04, 8'h00, 8'h08, 8'h02};

	// Output faults land on single channels so the group bit must fold them
	assign out_short = {1'b0, flt[0], 2'b00};
	assign out_overload = {flt[1], 3'b000};
	assign {sen_surge, act_surge, sen_under, sen_overload, act_under, act_short} = flt[7:2];

	iopif_core u_iopif_core (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .in_pin4, .in_pin2, .out_short, .out_overload, .act_short,
		.act_under, .act_surge, .sen_overload, .sen_under, .sen_surge, .overtemp, .dout,
		.status_word, .in_image, .station_fault_lamp, .alarm_incoming, .alarm_outgoing,
		.alarm_entry, .irq);
	iopif_ctrl_model u_iopif_ctrl_model (.pclk, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr);

	// Clock of 100 ns
	initial
	begin
		pclk = 1'b0;
		forever #50 pclk = ~pclk;
	end

	// Verdict and end of run
	task automatic wrap_up;
		if (n_errors == 0 && num_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : wrap_up

	// Value compare
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		num_checks++;
		if (got !== exp)
		begin
			n_errors++;
			$display("[ERR] %s exp %h got %h", nm, exp, got);
		end
	endtask : chk

	// Register access wrappers
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic e;
		u_iopif_ctrl_model.xfer(1'b1, a, d, q, e);
	endtask : wr
	task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] q;
		logic e;
		u_iopif_ctrl_model.xfer(1'b0, a, 32'h00000000, q, e);
		chk(nm, exp, q);
	endtask : rdc

	// Output check after the register-to-pin delay
	task automatic dchk(input logic [3:0] exp);
		repeat (3) @(posedge pclk);
		chk("dout", 32'(exp), 32'(dout));
	endtask : dchk

	// Input mapping
	task automatic t_inputs;
		@(posedge pclk);
		in_pin4 <= 4'h5;
		in_pin2 <= 4'hA;
		repeat (5) @(posedge pclk);
		chk("in_image", 32'h00000099, 32'(in_image));
		rdc("in_reg", iopif_pkg::OFS_IN_IMAGE, 32'h00000099);
	endtask : t_inputs

	// Each fault alone, status word and diagnostic store; alarms stay masked
	task automatic t_status;
		for (int k = 0; k < 8; k++)
		begin
			@(posedge pclk);
			flt <= 8'h01 << k;
			repeat (5) @(posedge pclk);
			chk("status", 32'(ST_EXP[k]), status_word);
			chk("lamp", 32'(DG_EXP[k] != 8'h00), 32'(station_fault_lamp));
			rdc("diag", iopif_pkg::OFS_DIAG_STORE, 32'(DG_EXP[k]));
			rdc("st_reg", iopif_pkg::OFS_STATUS_WORD, 32'(ST_EXP[k]));
			@(posedge pclk);
			flt <= 8'h00;
			repeat (5) @(posedge pclk);
		end
		chk("irq_masked", 32'h0, 32'(irq));
		rdc("irq_sts", iopif_pkg::OFS_IRQ_STATUS, 32'h00000003);
	endtask : t_status

	// Incoming and outgoing alarm with interrupt raise, clear and mask
	task automatic t_diag;
		wr(iopif_pkg::OFS_IRQ_CLEAR, 32'h00000003);
		wr(iopif_pkg::OFS_IRQ_ENABLE, 32'h00000001);
		@(posedge pclk);
		overtemp <= 1'b1;
		for (int n = 0; n < 10 && alarm_incoming !== 1'b1; n++)
			@(posedge pclk);
		chk("inc", 32'h1, 32'(alarm_incoming));
		chk("entry", 32'h1, 32'(alarm_entry));
		repeat (3) @(posedge pclk);
		chk("irq", 32'h1, 32'(irq));
		chk("lamp", 32'h1, 32'(station_fault_lamp));
		wr(iopif_pkg::OFS_IRQ_CLEAR, 32'h00000001);
		repeat (2) @(posedge pclk);
		chk("irq_clr", 32'h0, 32'(irq));
		overtemp <= 1'b0;
		for (int n = 0; n < 10 && alarm_outgoing !== 1'b1; n++)
			@(posedge pclk);
		chk("out", 32'h1, 32'(alarm_outgoing));
		chk("entry", 32'h1, 32'(alarm_entry));
		repeat (3) @(posedge pclk);
		chk("lamp", 32'h0, 32'(station_fault_lamp));
		chk("irq_mask", 32'h0, 32'(irq));
		rdc("irq_sts", iopif_pkg::OFS_IRQ_STATUS, 32'h00000002);
	endtask : t_diag

	// Cyclic data, then every failsafe code with the link lost
	task automatic t_failsafe;
		dchk(4'h0);
		wr(iopif_pkg::OFS_OUT_IMAGE, 32'h000000F5);
		wr(iopif_pkg::OFS_LINK_CTRL, 32'h00000001);
		dchk(4'h5);
		wr(iopif_pkg::OFS_FS_POLICY, 32'h00000002);
		wr(iopif_pkg::OFS_LINK_CTRL, 32'h00000000);
		dchk(4'h5);
		// New cyclic data while the link is down must not reach the pins under hold
		wr(iopif_pkg::OFS_OUT_IMAGE, 32'h0000000A);
		dchk(4'h5);
		wr(iopif_pkg::OFS_FS_POLICY, 32'h00000001);
		dchk(4'hF);
		wr(iopif_pkg::OFS_FS_POLICY, 32'h00000003);
		wr(iopif_pkg::OFS_FS_PATTERN, 32'h1234FFF6);
		dchk(4'h6);
		wr(iopif_pkg::OFS_FS_POLICY, 32'h00000000);
		dchk(4'h0);
		rdc("pattern", iopif_pkg::OFS_FS_PATTERN, 32'h0000FFF6);
	endtask : t_failsafe

	// Reset in mid-run brings outputs and parameters back to their reset values
	task automatic t_reset;
		wr(iopif_pkg::OFS_FS_POLICY, 32'h00000001);
		dchk(4'hF);
		@(posedge pclk);
		presetn <= 1'b0;
		@(posedge pclk);
		chk("dout_rst", 32'h0, 32'(dout));
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		dchk(4'h0);
		rdc("policy_rst", iopif_pkg::OFS_FS_POLICY, 32'h00000000);
		rdc("pattern_rst", iopif_pkg::OFS_FS_PATTERN, 32'h00000000);
	endtask : t_reset

	// Unmapped address and a write to a read-only word
	task automatic t_refuse;
		logic [31:0] q;
		logic e;
		u_iopif_ctrl_model.xfer(1'b0, 8'hFC, 32'h00000000, q, e);
		chk("slverr", 32'h1, 32'(e));
		chk("rdata", 32'h0, q);
		wr(iopif_pkg::OFS_STATUS_WORD, 32'hFFFFFFFF);
		rdc("st_ro", iopif_pkg::OFS_STATUS_WORD, 32'h00000000);
	endtask : t_refuse

	// Main sequence
	initial
	begin
		presetn = 1'b0;
		in_pin4 = 4'h0;
		in_pin2 = 4'h0;
		flt = 8'h00;
		overtemp = 1'b0;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		rdc("policy", iopif_pkg::OFS_FS_POLICY, 32'h00000000);
		rdc("pattern", iopif_pkg::OFS_FS_PATTERN, 32'h00000000);
		t_inputs;
		t_status;
		t_diag;
		t_failsafe;
		t_refuse;
		t_reset;
		wrap_up;
	end

	// Hang guard well beyond the expected run
	initial
	begin
		repeat (5000) @(posedge pclk);
		n_errors++;
		wrap_up;
	end
endmodule : tb
`default_nettype wire

// ---- hdl/iopif_core.sv ----
// Process image, status word, failsafe outputs and diagnostic store with APB registers
`timescale 1ns/1ns
`default_nettype none

module iopif_core #(
	parameter int OUT_CH = 4
) (
	// APB slave
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Field pins, asynchronous
	input wire logic [3:0] in_pin4,
	input wire logic [3:0] in_pin2,
	input wire logic [OUT_CH-1:0] out_short,
	input wire logic [OUT_CH-1:0] out_overload,
	input wire logic act_short,
	input wire logic act_under,
	input wire logic act_surge,
	input wire logic sen_overload,
	input wire logic sen_under,
	input wire logic sen_surge,
	input wire logic overtemp,
	// Process image and indicators
	output logic [OUT_CH-1:0] dout,
	output logic [31:0] status_word,
	output logic [7:0] in_image,
	output logic station_fault_lamp,
	// Alarms toward the controller
	output logic alarm_incoming,
	output logic alarm_outgoing,
	output logic [7:0] alarm_entry,
	output logic irq
);

	localparam int NSYNC = 8 + 2 * OUT_CH + 7;

	logic [NSYNC-1:0] sync1_r;
	logic [NSYNC-1:0] sync2_r;
	logic [7:0] in_byte;
	logic grp_short;
	logic grp_ovl;
	logic s_act_short;
	logic s_act_under;
	logic s_act_surge;
	logic s_sen_ovl;
	logic s_sen_under;
	logic s_sen_surge;
	logic s_overtemp;
	logic [31:0] status_nxt;
	logic [7:0] diag_nxt;
	logic [7:0] diag_r;
	logic [7:0] out_image_r;
	logic link_valid_r;
	logic [1:0] fs_policy_r;
	logic [15:0] fs_pattern_r;
	logic [1:0] irq_sts_r;
	logic [1:0] irq_en_r;
	logic [OUT_CH-1:0] dout_nxt;
	logic [31:0] rdata_nxt;
	logic map_hit;
	logic wr_en;
	logic [1:0] irq_set;

	// Two-flop synchroniser for every field pin; only the second stage is read
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			sync1_r <= '0;
			sync2_r <= '0;
		end
		else
		begin
			sync1_r <= {overtemp, sen_surge, sen_under, sen_overload, act_surge, act_under,
				act_short, out_overload, out_short, in_pin2, in_pin4};
			sync2_r <= sync1_r;
		end
	end

	// Unpack synchronised pins
	assign s_overtemp = sync2_r[NSYNC-1];
	assign s_sen_surge = sync2_r[NSYNC-2];
	assign s_sen_under = sync2_r[NSYNC-3];
	assign s_sen_ovl = sync2_r[NSYNC-4];
	assign s_act_surge = sync2_r[NSYNC-5];
	assign s_act_under = sync2_r[NSYNC-6];
	assign s_act_short = sync2_r[NSYNC-7];
	// Channels fold into one group bit; a single channel is never singled out
	assign grp_ovl = |sync2_r[8+OUT_CH +: OUT_CH];
	assign grp_short = |sync2_r[8 +: OUT_CH];

	// Interleave connector pins into the input byte
	genvar g;
	generate
		for (g = 0; g < 4; g++)
		begin : g_in
			assign in_byte[2*g] = sync2_r[g];
			assign in_byte[2*g+1] = sync2_r[4+g];
		end
	endgenerate

	// Status word; upper bits are reserved and read zero
	always_comb
	begin
		status_nxt = '0;
		status_nxt[iopif_pkg::ST_OUT_SHORT] = grp_short;
		status_nxt[iopif_pkg::ST_OUT_OVL] = grp_ovl;
		status_nxt[iopif_pkg::ST_ACT_SHORT] = s_act_short;
		status_nxt[iopif_pkg::ST_ACT_UNDER] = s_act_under;
		status_nxt[iopif_pkg::ST_SEN_OVL] = s_sen_ovl;
		status_nxt[iopif_pkg::ST_SEN_UNDER] = s_sen_under;
	end

	// Process input words refreshed on every clock
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			status_word <= '0;
			in_image <= '0;
		end
		else
		begin
			status_word <= status_nxt;
			in_image <= in_byte;
		end
	end

	// Diagnostic sources, one entry each
	always_comb
	begin
		diag_nxt = '0;
		diag_nxt[iopif_pkg::DG_OVERTEMP] = s_overtemp;
		diag_nxt[iopif_pkg::DG_SEN_SURGE] = s_sen_surge;
		diag_nxt[iopif_pkg::DG_SEN_OVL] = s_sen_ovl;
		diag_nxt[iopif_pkg::DG_ACT_SURGE] = s_act_surge;
		diag_nxt[iopif_pkg::DG_ACT_UNDER] = s_act_under;
		diag_nxt[iopif_pkg::DG_ACT_SHORT] = s_act_short;
		diag_nxt[iopif_pkg::DG_OUT_SHORT] = grp_short;
		diag_nxt[iopif_pkg::DG_OUT_OVL] = grp_ovl;
	end

	// Store follows the conditions; edges become alarms with the entry mask
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			diag_r <= '0;
			alarm_incoming <= 1'b0;
			alarm_outgoing <= 1'b0;
			alarm_entry <= '0;
			station_fault_lamp <= 1'b0;
		end
		else
		begin
			diag_r <= diag_nxt;
			alarm_incoming <= |(diag_nxt & ~diag_r);
			alarm_outgoing <= |(diag_r & ~diag_nxt);
			alarm_entry <= diag_nxt ^ diag_r;
			station_fault_lamp <= |diag_nxt;
		end
	end

	// APB decode; access cycle completes with pready high
	assign wr_en = psel && penable && pready && pwrite;
	always_comb
	begin
		map_hit = 1'b1;
		rdata_nxt = '0;
		case (paddr)
			iopif_pkg::OFS_STATUS_WORD: rdata_nxt = status_word;
			iopif_pkg::OFS_IN_IMAGE: rdata_nxt = {24'h000000, in_image};
			iopif_pkg::OFS_OUT_IMAGE: rdata_nxt = {24'h000000, out_image_r};
			iopif_pkg::OFS_LINK_CTRL: rdata_nxt = {31'h00000000, link_valid_r};
			iopif_pkg::OFS_FS_POLICY: rdata_nxt = {30'h00000000, fs_policy_r};
			iopif_pkg::OFS_FS_PATTERN: rdata_nxt = {16'h0000, fs_pattern_r};
			iopif_pkg::OFS_DIAG_STORE: rdata_nxt = {24'h000000, diag_r};
			iopif_pkg::OFS_IRQ_STATUS: rdata_nxt = {30'h00000000, irq_sts_r};
			iopif_pkg::OFS_IRQ_CLEAR: rdata_nxt = '0;
			iopif_pkg::OFS_IRQ_ENABLE: rdata_nxt = {30'h00000000, irq_en_r};
			default: map_hit = 1'b0;
		endcase
	end

	// No wait state: answer is prepared in the setup cycle
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= '0;
		end
		else
		begin
			pready <= psel && !penable;
			pslverr <= psel && !penable && !map_hit;
			prdata <= (psel && !penable && !pwrite) ? rdata_nxt : '0;
		end
	end

	// Cyclic output data and startup parameters written by the controller side
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			out_image_r <= iopif_pkg::RST_OUT_IMAGE;
			link_valid_r <= 1'b0;
			fs_policy_r <= iopif_pkg::RST_FS_POLICY;
			fs_pattern_r <= iopif_pkg::RST_FS_PATTERN;
			irq_en_r <= iopif_pkg::RST_IRQ_ENABLE;
		end
		else if (wr_en)
		begin
			case (paddr)
				iopif_pkg::OFS_OUT_IMAGE: out_image_r <= pwdata[7:0];
				iopif_pkg::OFS_LINK_CTRL: link_valid_r <= pwdata[0];
				iopif_pkg::OFS_FS_POLICY: fs_policy_r <= pwdata[1:0];
				iopif_pkg::OFS_FS_PATTERN: fs_pattern_r <= pwdata[15:0];
				iopif_pkg::OFS_IRQ_ENABLE: irq_en_r <= pwdata[1:0];
				default: out_image_r <= out_image_r;
			endcase
		end
	end

	// Output selection: live data while linked, otherwise the failsafe policy
	always_comb
	begin
		dout_nxt = out_image_r[OUT_CH-1:0];
		if (!link_valid_r)
		begin
			case (iopif_pkg::iopif_fs_t'(fs_policy_r))
				iopif_pkg::IOPIF_FS_CLEAR: dout_nxt = '0;
				iopif_pkg::IOPIF_FS_SET: dout_nxt = '1;
				iopif_pkg::IOPIF_FS_HOLD: dout_nxt = dout;
				iopif_pkg::IOPIF_FS_SUBST: dout_nxt = fs_pattern_r[OUT_CH-1:0];
				default: dout_nxt = '0;
			endcase
		end
	end

	// Output register; hold keeps what was last driven
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			dout <= '0;
		else
			dout <= dout_nxt;
	end

	// Sticky alarm events; a new event wins over a clear in the same cycle
	assign irq_set = {alarm_outgoing, alarm_incoming};
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			irq_sts_r <= '0;
		else if (wr_en && paddr == iopif_pkg::OFS_IRQ_CLEAR)
			irq_sts_r <= (irq_sts_r & ~pwdata[1:0]) | irq_set;
		else
			irq_sts_r <= irq_sts_r | irq_set;
	end

	// Level interrupt, one cycle behind the status
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			irq <= 1'b0;
		else
			irq <= |(irq_sts_r & irq_en_r);
	end

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	a_status_upper: assert property (status_word[31:6] == 26'h0000000)
		else $error("reserved status bits not zero");

	a_status_map: assert property (##1 status_word[3:0] ==
		{$past(s_act_under), $past(s_act_short), $past(grp_ovl), $past(grp_short)})
		else $error("status word bits do not follow faults");

	a_status_live: assert property ($rose(s_sen_under) |=> status_word[5])
		else $error("status word not refreshed");

	a_in_pins: assert property (##1 in_image ==
		{$past(sync2_r[7]), $past(sync2_r[3]), $past(sync2_r[6]), $past(sync2_r[2]),
		$past(sync2_r[5]), $past(sync2_r[1]), $past(sync2_r[4]), $past(sync2_r[0])})
		else $error("input byte mapping wrong");

	a_out_live: assert property (link_valid_r |=> dout == $past(out_image_r[3:0]))
		else $error("live outputs differ from output byte");

	a_fs_clear: assert property (!link_valid_r && fs_policy_r == 2'h0 |=> dout == '0)
		else $error("failsafe clear not applied");

	a_fs_set: assert property (!link_valid_r && fs_policy_r == 2'h1 |=> dout == '1)
		else $error("failsafe set not applied");

	a_fs_hold: assert property (!link_valid_r && fs_policy_r == 2'h2 |=> $stable(dout))
		else $error("failsafe hold changed outputs");

	a_fs_subst: assert property (!link_valid_r && fs_policy_r == 2'h3
		|=> dout == $past(fs_pattern_r[3:0]))
		else $error("substitute pattern not applied");

	a_alarm_in: assert property ($rose(s_overtemp)
		|=> alarm_incoming && alarm_entry[0] && diag_r[0])
		else $error("incoming alarm missing");

	a_alarm_out: assert property ($fell(grp_short) |=> alarm_outgoing && alarm_entry[6])
		else $error("outgoing alarm missing");

	a_lamp_store: assert property (##1 station_fault_lamp == ($past(diag_nxt) != 8'h00))
		else $error("station fault lamp wrong");

	a_group_diag: assert property (sync2_r[8] |=> alarm_entry[6] || diag_r[6])
		else $error("channel short not reported in group");

endmodule : iopif_core

`default_nettype wire

// ---- hdl/iopif_pkg.sv ----
// Package with register map, field positions and reset values of the I/O image block
package iopif_pkg;

	// Register byte offsets
	localparam logic [7:0] OFS_STATUS_WORD = 8'h00;
	localparam logic [7:0] OFS_IN_IMAGE = 8'h04;
	localparam logic [7:0] OFS_OUT_IMAGE = 8'h08;
	localparam logic [7:0] OFS_LINK_CTRL = 8'h0C;
	localparam logic [7:0] OFS_FS_POLICY = 8'h10;
	localparam logic [7:0] OFS_FS_PATTERN = 8'h14;
	localparam logic [7:0] OFS_DIAG_STORE = 8'h18;
	localparam logic [7:0] OFS_IRQ_STATUS = 8'h1C;
	localparam logic [7:0] OFS_IRQ_CLEAR = 8'h20;
	localparam logic [7:0] OFS_IRQ_ENABLE = 8'h24;

	// Status word field positions
	localparam int ST_OUT_SHORT = 0;
	localparam int ST_OUT_OVL = 1;
	localparam int ST_ACT_SHORT = 2;
	localparam int ST_ACT_UNDER = 3;
	localparam int ST_SEN_OVL = 4;
	localparam int ST_SEN_UNDER = 5;
	localparam int ST_USED = 6;

	// Diagnostic store entry positions
	localparam int DG_OVERTEMP = 0;
	localparam int DG_SEN_SURGE = 1;
	localparam int DG_SEN_OVL = 2;
	localparam int DG_ACT_SURGE = 3;
	localparam int DG_ACT_UNDER = 4;
	localparam int DG_ACT_SHORT = 5;
	localparam int DG_OUT_SHORT = 6;
	localparam int DG_OUT_OVL = 7;
	localparam int DG_COUNT = 8;

	// Interrupt status bits
	localparam int IRQ_INCOMING = 0;
	localparam int IRQ_OUTGOING = 1;
	localparam int IRQ_COUNT = 2;

	// Values after reset
	localparam logic [1:0] RST_FS_POLICY = 2'h0;
	localparam logic [15:0] RST_FS_PATTERN = 16'h0000;
	localparam logic [7:0] RST_OUT_IMAGE = 8'h00;
	localparam logic [1:0] RST_IRQ_ENABLE = 2'h0;

	// Failsafe substitute-value policy codes
	typedef enum logic [1:0] {
		IOPIF_FS_CLEAR = 2'b00,
		IOPIF_FS_SET = 2'b01,
		IOPIF_FS_HOLD = 2'b10,
		IOPIF_FS_SUBST = 2'b11
	} iopif_fs_t;

endpackage : iopif_pkg
